// ### verilog/zero_point_ctrl.sv
// zero point (datum) control for an absolute angle encoder
// Summary of operation
// - position is reported relative to the active datum; datum reads zero
// - factory datum is the active datum until a new one is captured
// - valid capture request stores present raw angle as new retained datum
// - valid restore request selects factory datum, retained over power loss
// - request is a line held low continuously for 3 s from power-up
// - output resolution is fixed at configuration, 10 to 22 bits
// - factory_datum_flag is 1 while factory datum active, else 0
`include "zero_point_defs.svh"
`default_nettype none
module zero_point_ctrl #(
    parameter int unsigned RES_BITS = 22,
    parameter int unsigned HOLD_CYCLES = `ZP_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic zero_set_b,
    input wire logic zero_reset_b,
    input wire logic [21:0] raw_angle,
    input wire zero_point_pkg::nv_image_t nv_rd,
    output logic nv_wr,
    output zero_point_pkg::nv_image_t nv_wr_data,
    output zero_point_pkg::pos_out_t pos_out,
    output logic pos_valid
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // flops start at the request level, so their fill-up cannot cancel a line held from power-up
    logic [1:0] set_sync_ff;
    logic [1:0] rst_sync_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            set_sync_ff <= `ZP_SYNC_RST;
            rst_sync_ff <= `ZP_SYNC_RST;
        end else begin
            set_sync_ff <= {set_sync_ff[0], zero_set_b};
            rst_sync_ff <= {rst_sync_ff[0], zero_reset_b};
        end
    end
    wire set_low = ~set_sync_ff[1];
    wire rst_low = ~rst_sync_ff[1];

    // ------------------------------------------------------------
    // power-up hold window
    // ------------------------------------------------------------
    // a line released at any time inside the window drops its request for good
    zero_point_pkg::zp_state_t state_ff;
    zero_point_pkg::zp_state_t nxt_state;
    logic [31:0] hold_cnt_ff;
    logic set_held_ff;
    logic rst_held_ff;
    logic [21:0] datum_ff;
    logic factory_ff;
    wire window_done = (hold_cnt_ff >= HOLD_CYCLES - 1);
    wire watching = (state_ff == zero_point_pkg::ST_WATCH);
    wire set_req = set_held_ff & set_low;
    wire rst_req = rst_held_ff & rst_low;
    // restore wins when both are held: the safer of the two outcomes
    wire commit_restore = rst_req;
    wire commit_capture = set_req & ~rst_req;
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            zero_point_pkg::ST_WATCH: if (window_done) nxt_state = zero_point_pkg::ST_COMMIT;
            zero_point_pkg::ST_COMMIT: nxt_state = zero_point_pkg::ST_RUN;
            zero_point_pkg::ST_RUN: nxt_state = zero_point_pkg::ST_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= zero_point_pkg::ST_WATCH;
            hold_cnt_ff <= 32'h0;
            set_held_ff <= 1'b1;
            rst_held_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (watching) begin
                hold_cnt_ff <= hold_cnt_ff + 32'h1;
                set_held_ff <= set_held_ff & set_low;
                rst_held_ff <= rst_held_ff & rst_low;
            end
        end
    end

    // ------------------------------------------------------------
    // active datum and retained image
    // ------------------------------------------------------------
    wire in_commit = (state_ff == zero_point_pkg::ST_COMMIT) & window_done;
    wire do_commit = watching & window_done & (set_req | rst_req);
    wire [21:0] nxt_datum = commit_capture ? raw_angle : `ZP_FACTORY_DATUM_RST;
    wire nv_has = nv_rd.datum_valid & ~nv_rd.factory_sel;
    // image comes from the committed flops, so a moving angle cannot skew the stored datum
    assign nv_wr_data = '{datum_valid: 1'b1, factory_sel: factory_ff, datum: datum_ff};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv_wr <= 1'b0;
            datum_ff <= `ZP_FACTORY_DATUM_RST;
            factory_ff <= 1'b1;
        end else begin
            nv_wr <= do_commit;
            if (do_commit) begin
                datum_ff <= nxt_datum;
                factory_ff <= commit_restore;
            end else if (watching && hold_cnt_ff == 32'h0) begin
                datum_ff <= nv_has ? nv_rd.datum : `ZP_FACTORY_DATUM_RST;
                factory_ff <= ~nv_has;
            end
        end
    end

    // ------------------------------------------------------------
    // position output
    // ------------------------------------------------------------
    // subtraction at full width wraps naturally at one turn
    wire [21:0] rel_angle = raw_angle - datum_ff;
    wire [21:0] res_mask = ~(22'h3FFFFF >> RES_BITS);
    wire [21:0] trunc = (rel_angle & res_mask) >> (`ZP_RAW_W - RES_BITS);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_out <= '0;
            pos_valid <= 1'b0;
        end else begin
            pos_out.position <= trunc;
            pos_out.factory_datum_flag <= factory_ff;
            pos_valid <= ~watching;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    initial begin
        if (RES_BITS < `ZP_RES_MIN || RES_BITS > `ZP_RES_MAX) $error("resolution out of range");
    end

    // ------------------------------------------------------------
    // check sequences
    // ------------------------------------------------------------
    // end of the power-up window, seen while still watching
    sequence s_window_end;
        watching && window_done;
    endsequence
    // write strobe that stands for exactly one cycle
    sequence s_write_pulse;
        nv_wr ##1 !nv_wr;
    endsequence
    // output flagged valid on two cycles in a row
    sequence s_output_live;
        pos_valid ##1 pos_valid;
    endsequence

    // ------------------------------------------------------------
    // datum commit and power-up load checks
    // ------------------------------------------------------------
    a_capture_store: assert property (@(posedge clk) disable iff (!rst_b)
        do_commit && commit_capture |=> datum_ff == $past(raw_angle) && !factory_ff && nv_wr)
        else $error("capture did not store raw angle");
    a_restore_store: assert property (@(posedge clk) disable iff (!rst_b)
        do_commit && commit_restore |=> datum_ff == `ZP_FACTORY_DATUM_RST && factory_ff && nv_wr)
        else $error("restore did not select factory datum");
    a_restore_wins: assert property (@(posedge clk) disable iff (!rst_b)
        do_commit && set_req && rst_req |=> factory_ff && datum_ff == `ZP_FACTORY_DATUM_RST)
        else $error("capture won over restore");
    a_image_stored: assert property (@(posedge clk) disable iff (!rst_b)
        do_commit |=> nv_wr_data.datum_valid && nv_wr_data.datum == $past(nxt_datum)
            && nv_wr_data.factory_sel == $past(commit_restore))
        else $error("retained image differs from committed datum");
    a_commit_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        do_commit |=> s_write_pulse)
        else $error("datum write strobe not one cycle");
    a_load_retained: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && watching && hold_cnt_ff == 32'h0 && !do_commit |=> factory_ff == !$past(nv_has)
            && datum_ff == ($past(nv_has) ? $past(nv_rd.datum) : `ZP_FACTORY_DATUM_RST))
        else $error("retained datum not loaded at power-up");

    // ------------------------------------------------------------
    // power-up window checks
    // ------------------------------------------------------------
    a_release_drops: assert property (@(posedge clk) disable iff (!rst_b)
        watching && !set_low |=> !set_held_ff)
        else $error("released set line still counted");
    a_restore_release: assert property (@(posedge clk) disable iff (!rst_b)
        watching && !rst_low |=> !rst_held_ff)
        else $error("released restore line still counted");
    a_cancel_sticks: assert property (@(posedge clk) disable iff (!rst_b)
        watching && !set_held_ff |=> !set_held_ff)
        else $error("cancelled set request came back");
    a_window_ends: assert property (@(posedge clk) disable iff (!rst_b)
        s_window_end |=> !watching)
        else $error("hold window did not close");
    a_no_early_write: assert property (@(posedge clk) disable iff (!rst_b)
        nv_wr |-> $past(window_done))
        else $error("datum written before hold window");
    a_write_slot: assert property (@(posedge clk) disable iff (!rst_b)
        nv_wr |-> in_commit)
        else $error("datum written outside commit state");
    a_single_write: assert property (@(posedge clk) disable iff (!rst_b)
        !watching |=> !nv_wr)
        else $error("datum written after power-up");
    a_no_request_keep: assert property (@(posedge clk) disable iff (!rst_b)
        s_window_end and (!set_req && !rst_req) |=> !nv_wr && $stable(datum_ff) && $stable(factory_ff))
        else $error("datum changed without a request");
    a_lines_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        !watching |=> $stable(datum_ff) && $stable(factory_ff))
        else $error("datum changed after power-up");

    // ------------------------------------------------------------
    // position output checks
    // ------------------------------------------------------------
    a_valid_after: assert property (@(posedge clk) disable iff (!rst_b)
        s_window_end |=> ##1 s_output_live)
        else $error("position not valid after window");
    a_flag_tracks: assert property (@(posedge clk) disable iff (!rst_b)
        !watching && !do_commit |=> pos_out.factory_datum_flag == $past(factory_ff))
        else $error("factory datum flag mismatch");
    a_flag_capture: assert property (@(posedge clk) disable iff (!rst_b)
        do_commit && commit_capture |=> ##1 !pos_out.factory_datum_flag)
        else $error("flag still set after capture");
    a_position_rel: assert property (@(posedge clk) disable iff (!rst_b)
        !watching |=> pos_out.position == ((22'($past(raw_angle) - $past(datum_ff)) & $past(res_mask))
            >> (`ZP_RAW_W - RES_BITS)))
        else $error("position not relative to datum");
    a_width_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (pos_out.position >> RES_BITS) == 22'h0)
        else $error("position wider than resolution");
    a_zero_datum: assert property (@(posedge clk) disable iff (!rst_b)
        !watching && raw_angle == datum_ff |=> pos_out.position == 22'h0)
        else $error("datum did not read zero");
endmodule
`default_nettype wire

// ### shared/zero_point_defs.svh
// timing and reset constants for the zero point control block
`ifndef ZERO_POINT_DEFS_SVH
`define ZERO_POINT_DEFS_SVH
`define ZP_CLK_HZ 40000000
`define ZP_HOLD_SEC 3
`define ZP_HOLD_CYCLES (`ZP_HOLD_SEC * `ZP_CLK_HZ)
`define ZP_RAW_W 22
`define ZP_RES_MIN 10
`define ZP_RES_MAX 22
`define ZP_FACTORY_DATUM_RST 22'h000000
`define ZP_SYNC_RST 2'h0
`endif

// ### shared/zero_point_pkg.sv
// types shared by the zero point control block
`default_nettype none
package zero_point_pkg;
    typedef enum logic [1:0] {
        ST_WATCH,
        ST_COMMIT,
        ST_RUN
    } zp_state_t;

    typedef struct packed {
        logic datum_valid;
        logic factory_sel;
        logic [21:0] datum;
    } nv_image_t;

    typedef struct packed {
        logic factory_datum_flag;
        logic [21:0] position;
    } pos_out_t;
endpackage
`default_nettype wire

// ### dv/zero_line_host.sv
// host model that drives the two datum request lines
`default_nettype none
module zero_line_host (
    input wire logic press_set,
    input wire logic press_reset,
    output logic zero_set_b,
    output logic zero_reset_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // an open line sits at the pull-up level, never at the last driven value
    assign zero_set_b = press_set ? 1'b0 : 1'b1;
    assign zero_reset_b = press_reset ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### dv/encoder_zero_point_control_bench.sv
// self-checking bench for the zero point control block
`default_nettype none
module encoder_zero_point_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SH = 6;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic press_set = 1'b0;
    logic press_reset = 1'b0;
    logic zero_set_b;
    logic zero_reset_b;
    logic nv_wr;
    logic pos_valid;
    logic [21:0] raw_angle = 22'h000000;
    zero_point_pkg::nv_image_t nv_rd = '0;
    zero_point_pkg::nv_image_t nv_wr_data;
    zero_point_pkg::nv_image_t last_wr;
    zero_point_pkg::pos_out_t pos_out;
    int error_cnt = 0;
    int checked = 0;
    int wr_cnt = 0;
    int wr_base = 0;
    zero_line_host i_zero_line_host (.press_set(press_set), .press_reset(press_reset),
        .zero_set_b(zero_set_b), .zero_reset_b(zero_reset_b));
    zero_point_ctrl #(.RES_BITS(22 - SH), .HOLD_CYCLES(20)) i_zero_point_ctrl (.clk(clk), .rst_b(rst_b),
        .zero_set_b(zero_set_b), .zero_reset_b(zero_reset_b), .raw_angle(raw_angle), .nv_rd(nv_rd),
        .nv_wr(nv_wr), .nv_wr_data(nv_wr_data), .pos_out(pos_out), .pos_valid(pos_valid));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // retained store: keeps its image across every reset, as power loss would
    always @(posedge clk) begin
        if (nv_wr === 1'b1) begin
            nv_rd <= nv_wr_data;
            last_wr <= nv_wr_data;
            wr_cnt <= wr_cnt + 1;
        end
    end
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // lines are held low from before reset release for hold cycles, then opened
    task automatic power_up(input logic s, input logic r, input int hold);
        int n;
        wr_base = wr_cnt;
        rst_b <= 1'b0;
        press_set <= s;
        press_reset <= r;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (hold) @(posedge clk);
        press_set <= 1'b0;
        press_reset <= 1'b0;
        n = 0;
        while (pos_valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check("pos_valid", 24'h000001, {23'h0, pos_valid});
    endtask
    task automatic check_pos(input logic flag, input logic [21:0] datum);
        logic [21:0] d;
        repeat (3) @(posedge clk);
        // sampled mid-cycle, then back on a rising edge for the next driver
        @(negedge clk);
        d = raw_angle - datum;
        check("pos_out", {1'b0, flag, d >> SH}, {1'b0, pos_out});
        @(posedge clk);
    endtask
    task automatic sc_factory;
        raw_angle <= 22'h2ABCDE;
        power_up(1'b0, 1'b0, 30);
        check("nv_wr count", 24'h000000, 24'(wr_cnt - wr_base));
        check_pos(1'b1, 22'h000000);
    endtask
    task automatic sc_capture;
        raw_angle <= 22'h123456;
        power_up(1'b1, 1'b0, 30);
        check("nv_wr count", 24'h000001, 24'(wr_cnt - wr_base));
        check("nv image", {2'b10, 22'h123456}, last_wr);
        check_pos(1'b0, 22'h123456);
        raw_angle <= 22'h023456;
        check_pos(1'b0, 22'h123456);
    endtask
    task automatic sc_cancel;
        raw_angle <= 22'h3FFFFF;
        power_up(1'b1, 1'b0, 10);
        check("nv_wr count", 24'h000000, 24'(wr_cnt - wr_base));
        check_pos(1'b0, 22'h123456);
    endtask
    task automatic sc_restore;
        power_up(1'b0, 1'b1, 30);
        check("factory_sel", 24'h000001, {23'h0, last_wr.factory_sel});
        check_pos(1'b1, 22'h000000);
        power_up(1'b0, 1'b0, 30);
        check_pos(1'b1, 22'h000000);
    endtask
    task automatic sc_both;
        raw_angle <= 22'h0ABCDE;
        power_up(1'b1, 1'b1, 30);
        check("nv_wr count", 24'h000001, 24'(wr_cnt - wr_base));
        check("nv image", {2'b11, 22'h000000}, last_wr);
        check_pos(1'b1, 22'h000000);
    endtask
    // a line pulled low after the window must change nothing
    task automatic sc_late;
        power_up(1'b0, 1'b0, 30);
        @(posedge clk);
        press_set <= 1'b1;
        repeat (30) @(posedge clk);
        press_set <= 1'b0;
        check("nv_wr count", 24'h000000, 24'(wr_cnt - wr_base));
        check_pos(1'b1, 22'h000000);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        sc_factory();
        sc_capture();
        sc_cancel();
        sc_restore();
        sc_both();
        sc_late();
        wrap_up();
    end
    // the scenarios need a few hundred cycles; 2000 means a hang
    initial begin
        #50000;
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
